// ===== src/hss_pkg.sv
// constants shared by the hardware single stepper and breakpoint logic
package hss_pkg;

    // ------------------------------------------------------------------
    // clock and debounce timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_KHZ = 40000;
    localparam int unsigned DEBOUNCE_MS = 10;
    localparam int unsigned DEBOUNCE_CYCLES = DEBOUNCE_MS * CLK_KHZ;
    localparam int unsigned DEB_CNT_W = 20;

    // ------------------------------------------------------------------
    // register indices, byte address is four times the index
    // ------------------------------------------------------------------
    localparam int unsigned PADDR_W = 8;
    localparam logic [7:0] IDX_TGT_LO = 8'h00;
    localparam logic [7:0] IDX_TGT_HI = 8'h01;
    localparam logic [7:0] IDX_ARM = 8'h02;
    localparam logic [7:0] IDX_STATUS = 8'h03;

    // ------------------------------------------------------------------
    // status register fields
    // ------------------------------------------------------------------
    localparam int unsigned STAT_EN_BIT = 0;
    localparam int unsigned STAT_FETCH_ONLY_BIT = 1;
    localparam int unsigned STAT_ARMED_BIT = 2;
    localparam int unsigned STAT_HOLD_BIT = 3;

    // byte address of a register index
    function automatic logic [PADDR_W-1:0] reg_addr(input logic [7:0] idx);
        reg_addr = PADDR_W'({idx[5:0], 2'b00});
    endfunction : reg_addr

endpackage : hss_pkg

// ===== src/hw_single_step_breakpoint.sv
// hardware single stepper with address-match breakpoint and apb registers
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module hw_single_step_breakpoint
    import hss_pkg::*;
#(
    parameter logic [DEB_CNT_W-1:0] DEB_CYCLES = DEB_CNT_W'(DEBOUNCE_CYCLES)
)
(
    // clock and power-on reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,

    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [PADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,

    // processor bus, asynchronous pins
    input wire logic bus_ale_i,
    input wire logic [15:0] bus_addr_i,
    input wire logic bus_opcode_fetch_i,
    input wire logic bus_mem_read_i,
    input wire logic bus_mem_write_i,
    input wire logic cpu_reset_i,

    // front panel pushbuttons, high while pressed
    input wire logic step_enable_button_i,
    input wire logic step_fetch_only_button_i,
    input wire logic step_all_button_i,
    input wire logic step_advance_button_i,

    // wait request to the processor and indicators
    output logic cpu_hold_o,
    output logic step_enable_led_o,
    output logic fetch_only_led_o,
    output logic break_armed_led_o
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        // bus pin synchronisers, bit 1 is the only one logic reads
        logic [1:0] ale_s;
        logic [1:0] opf_s;
        logic [1:0] mrd_s;
        logic [1:0] mwr_s;
        logic [1:0] crst_s;
        logic [15:0] addr_s1;
        logic [15:0] addr_s2;
        logic ale_d;
        // stepper and breakpoint
        logic en;
        logic fetch_only;
        logic armed;
        logic [7:0] tgt_lo;
        logic [7:0] tgt_hi;
        logic hold;
        // apb answer
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } step_state_t;

    step_state_t s_r;
    step_state_t s_nxt;

    logic en_press;
    logic fo_press;
    logic all_press;
    logic adv_press;

    // ------------------------------------------------------------------
    // decoding helpers
    // ------------------------------------------------------------------
    // bus cycle kinds that stop the processor in the given step mode
    function automatic logic selects_cycle(
        input logic only_fetch,
        input logic opf,
        input logic mrd,
        input logic mwr
    );
        if (only_fetch)
        begin
            selects_cycle = opf;
        end
        else
        begin
            // operand fetches appear on the bus as memory reads
            selects_cycle = opf | mrd | mwr;
        end
    endfunction : selects_cycle

    // full sixteen-bit compare; a partial one would also stop on aliases
    function automatic logic hits_target(
        input logic [15:0] addr,
        input logic [15:0] tgt
    );
        hits_target = (addr == tgt);
    endfunction : hits_target

    // unaligned addresses never equal a register address, so they miss
    function automatic logic reg_hit(
        input logic [PADDR_W-1:0] addr,
        input logic [7:0] idx
    );
        reg_hit = (addr == reg_addr(idx));
    endfunction : reg_hit

    // status word seen by software; bits above the hold flag read as zero
    function automatic logic [31:0] pack_status(
        input logic en,
        input logic only_fetch,
        input logic armed,
        input logic hold
    );
        pack_status = '0;
        pack_status[STAT_EN_BIT] = en;
        pack_status[STAT_FETCH_ONLY_BIT] = only_fetch;
        pack_status[STAT_ARMED_BIT] = armed;
        pack_status[STAT_HOLD_BIT] = hold;
    endfunction : pack_status

    // ------------------------------------------------------------------
    // pushbutton filters
    // ------------------------------------------------------------------
    press_debounce #(
        .DEB_CYCLES(DEB_CYCLES)
    ) u_deb_enable (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .pad_i(step_enable_button_i),
        .press_o(en_press)
    );

    press_debounce #(
        .DEB_CYCLES(DEB_CYCLES)
    ) u_deb_fetch_only (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .pad_i(step_fetch_only_button_i),
        .press_o(fo_press)
    );

    press_debounce #(
        .DEB_CYCLES(DEB_CYCLES)
    ) u_deb_all (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .pad_i(step_all_button_i),
        .press_o(all_press)
    );

    press_debounce #(
        .DEB_CYCLES(DEB_CYCLES)
    ) u_deb_advance (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .pad_i(step_advance_button_i),
        .press_o(adv_press)
    );

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    logic cyc_start;
    logic cyc_selected;
    logic addr_match;
    logic apb_setup;
    logic apb_wr;
    logic cpu_in_reset;
    logic [15:0] target;
    logic [31:0] status_word;

    always_comb
    begin
        s_nxt = s_r;

        // --------------------------------------------------------------
        // pin synchronisers
        // --------------------------------------------------------------
        // two flops on every pin before use
        s_nxt.ale_s = {s_r.ale_s[0], bus_ale_i};
        s_nxt.opf_s = {s_r.opf_s[0], bus_opcode_fetch_i};
        s_nxt.mrd_s = {s_r.mrd_s[0], bus_mem_read_i};
        s_nxt.mwr_s = {s_r.mwr_s[0], bus_mem_write_i};
        s_nxt.crst_s = {s_r.crst_s[0], cpu_reset_i};
        // the address is steady around the strobe, so a per-bit
        // synchroniser is safe as long as the strobe is read the same way
        s_nxt.addr_s1 = bus_addr_i;
        s_nxt.addr_s2 = s_r.addr_s1;
        s_nxt.ale_d = s_r.ale_s[1];

        cpu_in_reset = s_r.crst_s[1];
        cyc_start = s_r.ale_s[1] & ~s_r.ale_d;
        target = {s_r.tgt_hi, s_r.tgt_lo};

        // --------------------------------------------------------------
        // cycle selection and breakpoint compare
        // --------------------------------------------------------------
        // all-cycles mode covers opcode and operand fetches and memory writes
        cyc_selected = selects_cycle(s_r.fetch_only, s_r.opf_s[1], s_r.mrd_s[1],
            s_r.mwr_s[1]);

        // any access type, target address only, whoever issues it
        addr_match = s_r.armed & cyc_start & hits_target(s_r.addr_s2, target);

        // --------------------------------------------------------------
        // stepper enable and mode
        // --------------------------------------------------------------
        // processor reset does not touch them
        if (en_press)
        begin
            s_nxt.en = ~s_r.en;
        end
        if (addr_match)
        begin
            s_nxt.en = 1'b1;
            s_nxt.armed = 1'b0;
        end
        if (fo_press)
        begin
            s_nxt.fetch_only = 1'b1;
        end
        else if (all_press)
        begin
            s_nxt.fetch_only = 1'b0;
        end

        // --------------------------------------------------------------
        // wait insertion
        // --------------------------------------------------------------
        // a new selected cycle outranks an advance pulse in the same clock
        if (cyc_start & ((s_r.en & cyc_selected) | addr_match))
        begin
            s_nxt.hold = 1'b1;
        end
        else if (s_r.hold & s_r.en & adv_press)
        begin
            s_nxt.hold = 1'b0;
        end
        if (!s_nxt.en)
        begin
            s_nxt.hold = 1'b0;
        end
        if (cpu_in_reset)
        begin
            // the stretched cycle is abandoned, the settings stay
            s_nxt.hold = 1'b0;
        end

        // --------------------------------------------------------------
        // register slave
        // --------------------------------------------------------------
        // apb: answer is prepared in the setup cycle, given in the access;
        // the write-only latches read back as zero, software keeps a copy
        status_word = pack_status(s_r.en, s_r.fetch_only, s_r.armed, s_r.hold);

        apb_setup = psel_i & ~penable_i;
        apb_wr = psel_i & penable_i & s_r.pready & pwrite_i & ~s_r.pslverr & pstrb_i[0];

        if (apb_setup)
        begin
            s_nxt.pready = 1'b1;
            s_nxt.prdata = '0;
            s_nxt.pslverr = 1'b0;
            unique case (paddr_i)
                reg_addr(IDX_TGT_LO),
                reg_addr(IDX_TGT_HI),
                reg_addr(IDX_ARM):
                begin
                    s_nxt.prdata = '0;
                end
                reg_addr(IDX_STATUS):
                begin
                    s_nxt.prdata = status_word;
                end
                default:
                begin
                    s_nxt.pslverr = 1'b1;
                end
            endcase
        end
        else if (psel_i & penable_i & s_r.pready)
        begin
            s_nxt.pready = 1'b0;
            s_nxt.pslverr = 1'b0;
            s_nxt.prdata = '0;
        end

        // --------------------------------------------------------------
        // target latches and arming
        // --------------------------------------------------------------
        // the latches are write-only; a write to the arm location arms
        if (apb_wr)
        begin
            if (reg_hit(paddr_i, IDX_TGT_LO))
            begin
                s_nxt.tgt_lo = pwdata_i[7:0];
            end
            if (reg_hit(paddr_i, IDX_TGT_HI))
            begin
                s_nxt.tgt_hi = pwdata_i[7:0];
            end
            if (reg_hit(paddr_i, IDX_ARM))
            begin
                // a fresh arm outranks a match in the same cycle
                s_nxt.armed = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // registers, cleared by power-on reset only
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign cpu_hold_o = s_r.hold;
    assign step_enable_led_o = s_r.en;
    assign fetch_only_led_o = s_r.fetch_only;
    assign break_armed_led_o = s_r.armed;
    assign prdata_o = s_r.prdata;
    assign pready_o = s_r.pready;
    assign pslverr_o = s_r.pslverr;

endmodule : hw_single_step_breakpoint

// ===== src/press_debounce.sv
// debounced pushbutton that yields one pulse per press
`timescale 1ns/1ps
module press_debounce
    import hss_pkg::*;
#(
    parameter logic [DEB_CNT_W-1:0] DEB_CYCLES = DEB_CNT_W'(DEBOUNCE_CYCLES)
)
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // pushbutton pad, high while pressed
    input wire logic pad_i,
    // one-cycle pulse per accepted press
    output logic press_o
);

    typedef struct packed {
        logic [1:0] sync;
        logic stable;
        logic [DEB_CNT_W-1:0] cnt;
        logic press;
    } deb_state_t;

    deb_state_t s_r;
    deb_state_t s_nxt;

    // ------------------------------------------------------------------
    // filter
    // ------------------------------------------------------------------
    // the level must hold for the whole window before it is believed;
    // contact bounce restarts the count
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.sync = {s_r.sync[0], pad_i};
        s_nxt.press = 1'b0;
        if (s_r.sync[1] == s_r.stable)
        begin
            s_nxt.cnt = '0;
        end
        else if (s_r.cnt >= DEB_CYCLES - DEB_CNT_W'(1))
        begin
            s_nxt.cnt = '0;
            s_nxt.stable = s_r.sync[1];
            s_nxt.press = s_r.sync[1];
        end
        else
        begin
            s_nxt.cnt = s_r.cnt + DEB_CNT_W'(1);
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign press_o = s_r.press;

endmodule : press_debounce

// ===== verification/cpu_bus_model.sv
// processor bus model that runs one bus cycle at a time
`timescale 1ns/1ps
module cpu_bus_model
(
    input wire logic core_clk_i,
    input wire logic hold_i,
    output logic ale_o = 1'b0,
    output logic [15:0] addr_o = 16'h0000,
    output logic [2:0] kind_o = 3'h0
);
    // kind_o is {opcode fetch, memory read, memory write}
    task automatic start(input logic [15:0] a, input logic [2:0] k, output logic held);
        addr_o <= a;
        kind_o <= k;
        @(posedge core_clk_i);
        ale_o <= 1'b1;
        // ready is sampled late enough for the synchronised hold
        repeat (6) @(posedge core_clk_i);
        held = hold_i;
    endtask : start

    task automatic finish(output logic ok);
        int n = 0;
        while (hold_i && n < 200)
        begin
            @(posedge core_clk_i);
            n++;
        end
        ok = !hold_i;
        ale_o <= 1'b0;
        kind_o <= 3'h0;
        // a released bus shows no stale address
        addr_o <= ~addr_o;
        repeat (3) @(posedge core_clk_i);
    endtask : finish
endmodule : cpu_bus_model

// ===== verification/hss_monitor.sv
// port checker for the stepper, breakpoint and register slave
`timescale 1ns/1ps
module hss_monitor
(
    input wire logic core_clk_i, rst_n_i, psel_i, penable_i, pready_o, pslverr_o,
    input wire logic cpu_reset_i, step_advance_button_i, cpu_hold_o,
    input wire logic step_enable_led_o, fetch_only_led_o, break_armed_led_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    chk_power_up_off: assert property ($rose(rst_n_i) |-> !step_enable_led_o && !cpu_hold_o)
        else $error("stepper not off after power-up");
    chk_hold_needs_en: assert property ($rose(cpu_hold_o) |-> step_enable_led_o)
        else $error("hold without enable");
    chk_disarm_enables: assert property ($fell(break_armed_led_o) |-> step_enable_led_o)
        else $error("disarm without enable");
    // a hold may only end through advance, disable or a processor reset
    chk_release_cause: assert property ($fell(cpu_hold_o) |-> step_advance_button_i ||
        !step_enable_led_o || cpu_reset_i || $past(cpu_reset_i, 3))
        else $error("hold dropped without cause");
    chk_disable_frees: assert property ($fell(step_enable_led_o) |-> ##[0:2] !cpu_hold_o)
        else $error("hold kept after disable");
    chk_cpu_reset_keeps: assert property (cpu_reset_i |=> $stable(step_enable_led_o) &&
        $stable(fetch_only_led_o) && $stable(break_armed_led_o))
        else $error("processor reset changed stepper");
    chk_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    chk_ready_timing: assert property (psel_i && !penable_i |=> pready_o)
        else $error("ready late");
    chk_err_with_ready: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    cover property ($rose(cpu_hold_o));
    cover property ($fell(break_armed_led_o));
    cover property (pslverr_o);
endmodule : hss_monitor

bind hw_single_step_breakpoint hss_monitor i_mon (.core_clk_i, .rst_n_i, .psel_i, .penable_i,
    .pready_o, .pslverr_o, .cpu_reset_i, .step_advance_button_i, .cpu_hold_o,
    .step_enable_led_o, .fetch_only_led_o, .break_armed_led_o);

// ===== verification/tb.sv
// self-checking bench for the stepper and breakpoint block
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
    $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module tb
    import hss_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, cpu_rst = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] btn = 4'h0;
    logic [15:0] addr;
    logic [2:0] kind;
    logic ale, pready, pslverr, hold, en_led, fo_led, arm_led, held, ok, er;
    int err_total = 0, n_checks = 0;

    hw_single_step_breakpoint #(.DEB_CYCLES(20'h4)) i_dut
    (
        .core_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
        .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'h1), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .bus_ale_i(ale), .bus_addr_i(addr),
        .bus_opcode_fetch_i(kind[2]), .bus_mem_read_i(kind[1]), .bus_mem_write_i(kind[0]),
        .cpu_reset_i(cpu_rst), .step_enable_button_i(btn[0]),
        .step_fetch_only_button_i(btn[1]), .step_all_button_i(btn[2]),
        .step_advance_button_i(btn[3]), .cpu_hold_o(hold), .step_enable_led_o(en_led),
        .fetch_only_led_o(fo_led), .break_armed_led_o(arm_led)
    );
    cpu_bus_model i_cpu (.core_clk_i(clk), .hold_i(hold), .ale_o(ale), .addr_o(addr),
        .kind_o(kind));

    initial
    begin
        forever #12.5 clk = ~clk;
    end

    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end while (!pready && n < 50);
        rd = prdata;
        er = pslverr;
        if (pready !== 1'b1)
        begin
            err_total++;
            test_done();
        end
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic stat(input logic [3:0] e);
        apb(1'b0, reg_addr(IDX_STATUS), 32'h0);
        `CHK(rd[3:0], e)
    endtask : stat

    // long presses so the shortened debounce accepts each one
    task automatic press(input int b);
        btn[b] <= 1'b1;
        repeat (12) @(posedge clk);
        btn[b] <= 1'b0;
        repeat (12) @(posedge clk);
    endtask : press

    task automatic cycle(input logic [15:0] a, input logic [2:0] k, input logic e);
        i_cpu.start(a, k, held);
        `CHK(held, e)
        if (held)
            press(3);
        i_cpu.finish(ok);
        `CHK(ok, 1'b1)
    endtask : cycle

    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        test_done();
    end

    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        `CHK({en_led, fo_led, arm_led, hold}, 4'h0)
        stat(4'h0);
        cycle(16'h0100, 3'h4, 1'b0);
        apb(1'b0, 8'h10, 32'h0);
        `CHK({er, rd}, 33'h1_0000_0000)
        press(0);
        `CHK(en_led, 1'b1)
        cycle(16'h0200, 3'h1, 1'b1);
        cycle(16'h0201, 3'h4, 1'b1);
        press(1);
        `CHK(fo_led, 1'b1)
        stat(4'h3);
        cycle(16'h0202, 3'h1, 1'b0);
        cycle(16'h0203, 3'h2, 1'b0);
        cycle(16'h0204, 3'h4, 1'b1);
        i_cpu.start(16'h0205, 3'h4, held);
        cpu_rst <= 1'b1;
        repeat (10) @(posedge clk);
        `CHK(hold, 1'b0)
        cpu_rst <= 1'b0;
        i_cpu.finish(ok);
        `CHK({held, ok}, 2'b11)
        stat(4'h3);
        press(2);
        `CHK(fo_led, 1'b0)
        press(0);
        stat(4'h0);
        // firmware loads both target bytes, then arms
        apb(1'b1, reg_addr(IDX_TGT_LO), 32'h34);
        apb(1'b1, reg_addr(IDX_TGT_HI), 32'h12);
        apb(1'b1, reg_addr(IDX_ARM), 32'h1);
        stat(4'h4);
        apb(1'b0, reg_addr(IDX_TGT_LO), 32'h0);
        `CHK({er, rd}, 33'h0)
        cycle(16'h1235, 3'h2, 1'b0);
        cycle(16'h1334, 3'h2, 1'b0);
        i_cpu.start(16'h1234, 3'h2, held);
        `CHK({held, en_led, arm_led}, 3'b110)
        press(0);
        i_cpu.finish(ok);
        `CHK(ok, 1'b1)
        cycle(16'h1234, 3'h1, 1'b0);
        apb(1'b1, reg_addr(IDX_ARM), 32'h1);
        stat(4'h4);
        test_done();
    end
endmodule : tb
